/* design/bcc_pkg.sv */
// register offsets, field positions and reset values for the bridge capability registers
// assumes a dword-addressed configuration port with byte enables
package bcc_pkg;

    // dword byte offsets
    localparam logic [7:0] BCC_OFS_PM_CSR   = 8'h94;
    localparam logic [7:0] BCC_OFS_SLOT_ID  = 8'ha0;
    localparam logic [7:0] BCC_OFS_CLK_CTRL = 8'ha4;
    localparam logic [7:0] BCC_OFS_SUBSYS   = 8'ha8;
    localparam logic [7:0] BCC_OFS_SUBSYS_ID= 8'hac;
    localparam logic [7:0] BCC_OFS_EXP_CAP  = 8'hb0;
    localparam logic [7:0] BCC_OFS_DEV_CAP  = 8'hb4;
    localparam logic [7:0] BCC_OFS_DEV_CTRL = 8'hb8;

    // capability ids and chain pointers
    localparam logic [7:0] BCC_SLOT_ID_CAP  = 8'h04;
    localparam logic [7:0] BCC_SUBSYS_CAP   = 8'h0d;
    localparam logic [7:0] BCC_EXP_CAP      = 8'h10;
    localparam logic [7:0] BCC_PTR_EXP      = 8'hb0;
    localparam logic [7:0] BCC_PTR_SLOT_ID  = 8'ha0;
    localparam logic [7:0] BCC_PTR_MSI      = 8'hf0;

    // identity codes: arbitrary neutral values
    localparam logic [15:0] BCC_CARD_MAKER  = 16'h0000;
    localparam logic [15:0] BCC_CARD_MODEL  = 16'h0000;

    // field positions
    localparam int BCC_PM_WAKE_EN_BIT   = 8;
    localparam int BCC_PM_WAKE_STS_BIT  = 15;
    localparam int BCC_CLK_STOPPED_BIT  = 13;
    localparam int BCC_CLKRUN_EN_BIT    = 14;
    localparam int BCC_CLKRUN_MODE_BIT  = 15;
    localparam int BCC_L0S_IDLE_BIT     = 16;
    localparam int BCC_EXT_TAG_BIT      = 8;

    // fixed capability codes and reset values
    localparam logic [3:0] BCC_CAP_VERSION   = 4'h1;
    localparam logic [3:0] BCC_PORT_FORWARD  = 4'h7;
    localparam logic [3:0] BCC_PORT_REVERSE  = 4'h8;
    localparam logic [2:0] BCC_MPS_SUPPORTED = 3'h2;
    localparam logic [2:0] BCC_MPS_RESET     = 3'h0;
    localparam logic [2:0] BCC_MRRS_RESET    = 3'h2;
    localparam logic [2:0] BCC_DEVCAP_RSVD   = 3'h1;
    localparam logic [1:0] BCC_PSTATE_D0     = 2'h0;
    localparam logic [1:0] BCC_PSTATE_D3     = 2'h3;
    localparam logic [1:0] BCC_CLK_STOP_CODE = 2'h3;
    localparam int         BCC_NUM_SLOT_CLKS = 4;
    localparam logic [2:0] BCC_STRAP_SAMPLE  = 3'h4;

endpackage : bcc_pkg

/* design/bcc_sync.sv */
// three-stage synchroniser with agreement filter for one asynchronous level
// assumes one core clock; the first stage feeds only the second
module bcc_sync
    import bcc_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_nrst,
    input  wire logic i_async,
    output logic      o_level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } bcc_sync_state_type;

    bcc_sync_state_type st_r;
    bcc_sync_state_type st_nxt;

    // a change counts only when the second and third stages agree
    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.s1  = i_async;
        st_nxt.s2  = st_r.s1;
        st_nxt.s3  = st_r.s2;
        if (st_r.s2 == st_r.s3)
        begin
            st_nxt.lvl = st_r.s3;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_level = st_r.lvl;

endmodule : bcc_sync

/* design/bcc_regs.sv */
// capability register bank: power management upper bits to device status
// assumes single-cycle configuration access from the upstream port, events on core clock
module bcc_regs
    import bcc_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_sticky_nrst,
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_rd,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic [3:0]  i_cfg_be,
    input  wire logic [31:0] i_cfg_wdata,
    output logic [31:0]      o_cfg_rdata,
    output logic             o_cfg_rvalid,
    input  wire logic        i_reverse_mode,
    input  wire logic        i_hotplug_strap,
    input  wire logic        i_slot_id_enable,
    input  wire logic        i_wake_event,
    input  wire logic        i_slot_ref_clk,
    input  wire logic        i_sec_bus_idle,
    input  wire logic        i_primary_req_pending,
    input  wire logic        i_power_limit_msg,
    input  wire logic [7:0]  i_power_limit_value,
    input  wire logic [1:0]  i_power_limit_scale,
    input  wire logic [3:0]  i_err_event,
    output logic             o_wake_request_out,
    output logic             o_slot0_bus_clock_out,
    output logic             o_slot1_bus_clock_out,
    output logic             o_slot2_bus_clock_out,
    output logic             o_slot3_bus_clock_out,
    output logic             o_slot_bus_clock_out,
    output logic             o_clkrun_enable,
    output logic             o_l0s_need_rx_idle,
    output logic [3:0]       o_err_report_enable,
    output logic [2:0]       o_max_payload,
    output logic [2:0]       o_max_read_request,
    output logic             o_ext_tag_enable,
    output logic             o_no_snoop_attr,
    output logic             o_cfg_retry_enable
);

    // sticky bits live on the power-on reset so a hot reset leaves them alone
    typedef struct packed {
        logic       wake_en;
        logic       wake_sts;
    } bcc_sticky_type;

    typedef struct packed {
        logic [1:0]  pstate;
        logic [4:0]  slot_num;
        logic        first_chassis;
        logic [7:0]  chassis;
        logic [7:0]  clk_en;
        logic        clk_stopped;
        logic        clkrun_en;
        logic        clkrun_mode;
        logic        l0s_idle;
        logic [1:0]  scramble;
        logic [7:0]  pwr_value;
        logic [1:0]  pwr_scale;
        logic [3:0]  err_rep_en;
        logic [2:0]  mps;
        logic        ext_tag;
        logic [2:0]  mrrs;
        logic        cfg_retry;
        logic [3:0]  err_sts;
        logic [31:0] rdata;
        logic        rvalid;
        logic        hp_present;
        logic        slot_id_on;
        logic [2:0]  strap_cnt;
    } bcc_state_type;

    bcc_state_type  st_r;
    bcc_state_type  st_nxt;
    bcc_sticky_type sk_r;
    bcc_sticky_type sk_nxt;

    logic hotplug_lvl;
    logic slot_id_lvl;

    // the hot-plug and slot id straps come from pins, so they pass the synchroniser; reverse mode is used directly
    bcc_sync u_sync_hotplug (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_async    (i_hotplug_strap),
        .o_level    (hotplug_lvl)
    );

    bcc_sync u_sync_slot_id (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_async    (i_slot_id_enable),
        .o_level    (slot_id_lvl)
    );

    // merge byte-enabled write data into an old dword
    function automatic logic [31:0] bcc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : bcc_merge

    logic        stop_allowed;
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic [31:0] clr_mask;

    // stop only in d3hot, or when idle with nothing pending in idle mode
    assign stop_allowed = st_r.clkrun_mode ? (i_sec_bus_idle && !i_primary_req_pending)
                                           : (st_r.pstate == BCC_PSTATE_D3);

    // read multiplexer: fixed headers plus live state
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (i_cfg_addr)
            BCC_OFS_PM_CSR:
            begin
                rd_word[1:0]                = st_r.pstate;
                rd_word[BCC_PM_WAKE_EN_BIT] = sk_r.wake_en;
                rd_word[BCC_PM_WAKE_STS_BIT]= sk_r.wake_sts;
                rd_word[23:22]              = 2'h0;
            end
            BCC_OFS_SLOT_ID:
            begin
                if (st_r.slot_id_on)
                begin
                    rd_word[7:0]   = BCC_SLOT_ID_CAP;
                    rd_word[15:8]  = BCC_PTR_EXP;
                    rd_word[20:16] = st_r.slot_num;
                    rd_word[21]    = st_r.first_chassis;
                    rd_word[31:24] = st_r.chassis;
                end
            end
            BCC_OFS_CLK_CTRL:
            begin
                rd_word[7:0]                 = st_r.clk_en;
                rd_word[BCC_CLK_STOPPED_BIT] = st_r.clk_stopped;
                rd_word[BCC_CLKRUN_EN_BIT]   = st_r.clkrun_en;
                rd_word[BCC_CLKRUN_MODE_BIT] = st_r.clkrun_mode;
                rd_word[BCC_L0S_IDLE_BIT]    = st_r.l0s_idle;
                rd_word[18:17]               = st_r.scramble;
            end
            BCC_OFS_SUBSYS:
            begin
                rd_word[7:0]  = BCC_SUBSYS_CAP;
                rd_word[15:8] = st_r.slot_id_on ? BCC_PTR_SLOT_ID : BCC_PTR_EXP;
            end
            BCC_OFS_SUBSYS_ID:
            begin
                rd_word = {BCC_CARD_MODEL, BCC_CARD_MAKER};
            end
            BCC_OFS_EXP_CAP:
            begin
                rd_word[7:0]   = BCC_EXP_CAP;
                rd_word[15:8]  = BCC_PTR_MSI;
                rd_word[19:16] = BCC_CAP_VERSION;
                rd_word[23:20] = i_reverse_mode ? BCC_PORT_REVERSE : BCC_PORT_FORWARD;
                rd_word[24]    = i_reverse_mode;
            end
            BCC_OFS_DEV_CAP:
            begin
                rd_word[2:0]   = BCC_MPS_SUPPORTED;
                rd_word[5]     = 1'b1;
                rd_word[12]    = st_r.hp_present;
                rd_word[13]    = st_r.hp_present;
                rd_word[14]    = st_r.hp_present;
                rd_word[17:15] = BCC_DEVCAP_RSVD;
                rd_word[25:18] = st_r.pwr_value;
                rd_word[27:26] = st_r.pwr_scale;
            end
            BCC_OFS_DEV_CTRL:
            begin
                rd_word[3:0]            = st_r.err_rep_en;
                rd_word[7:5]            = st_r.mps;
                rd_word[BCC_EXT_TAG_BIT]= st_r.ext_tag;
                rd_word[14:12]          = st_r.mrrs;
                rd_word[15]             = st_r.cfg_retry;
                rd_word[19:16]          = st_r.err_sts;
                rd_word[20]             = 1'b1; // aux power detected
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // lane-merged write word; clear mask only on enabled lanes
    assign wr_word  = bcc_merge(rd_word, i_cfg_wdata, i_cfg_be);
    assign clr_mask = bcc_merge(32'h0000_0000, i_cfg_wdata, i_cfg_be);

    // next state for the core register set
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.rvalid = i_cfg_rd;
        if (i_cfg_rd)
        begin
            st_nxt.rdata = rd_word;
        end
        // straps are caught once, only after the synchronisers have filled
        st_nxt.strap_cnt = (st_r.strap_cnt > BCC_STRAP_SAMPLE) ? st_r.strap_cnt : 3'(st_r.strap_cnt + 3'h1);
        if (st_r.strap_cnt == BCC_STRAP_SAMPLE)
        begin
            st_nxt.hp_present = hotplug_lvl && !i_reverse_mode;
            st_nxt.slot_id_on = slot_id_lvl;
        end
        st_nxt.clk_stopped = st_r.clkrun_en && stop_allowed;
        if (i_power_limit_msg)
        begin
            st_nxt.pwr_value = i_power_limit_value;
            st_nxt.pwr_scale = i_power_limit_scale;
        end
        if (i_cfg_wr)
        begin
            unique case (i_cfg_addr)
                BCC_OFS_PM_CSR:
                begin
                    // unimplemented d1/d2 codes leave the state untouched
                    if (i_cfg_be[0] && (wr_word[1:0] == BCC_PSTATE_D0 || wr_word[1:0] == BCC_PSTATE_D3))
                    begin
                        st_nxt.pstate = wr_word[1:0];
                    end
                end
                BCC_OFS_SLOT_ID:
                begin
                    if (st_r.slot_id_on)
                    begin
                        st_nxt.slot_num      = wr_word[20:16];
                        st_nxt.first_chassis = wr_word[21];
                        st_nxt.chassis       = wr_word[31:24];
                    end
                end
                BCC_OFS_CLK_CTRL:
                begin
                    st_nxt.clk_en      = wr_word[7:0];
                    st_nxt.clkrun_en   = wr_word[BCC_CLKRUN_EN_BIT];
                    st_nxt.clkrun_mode = wr_word[BCC_CLKRUN_MODE_BIT];
                    st_nxt.l0s_idle    = wr_word[BCC_L0S_IDLE_BIT];
                    st_nxt.scramble    = wr_word[18:17];
                end
                BCC_OFS_DEV_CTRL:
                begin
                    st_nxt.err_rep_en = wr_word[3:0];
                    st_nxt.mps        = wr_word[7:5];
                    st_nxt.ext_tag    = wr_word[BCC_EXT_TAG_BIT];
                    st_nxt.mrrs       = wr_word[14:12];
                    st_nxt.cfg_retry  = wr_word[15];
                    st_nxt.err_sts    = st_r.err_sts & ~clr_mask[19:16];
                end
                default:
                begin
                end
            endcase
        end
        // a new error wins over a clear in the same cycle
        st_nxt.err_sts = st_nxt.err_sts | i_err_event;
    end

    // sticky next state; a wake event wins over a clear
    always_comb
    begin
        sk_nxt = sk_r;
        if (i_cfg_wr && i_cfg_addr == BCC_OFS_PM_CSR && i_cfg_be[1])
        begin
            sk_nxt.wake_en  = i_cfg_wdata[BCC_PM_WAKE_EN_BIT];
            sk_nxt.wake_sts = sk_r.wake_sts && !i_cfg_wdata[BCC_PM_WAKE_STS_BIT];
        end
        sk_nxt.wake_sts = sk_nxt.wake_sts || i_wake_event;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_r          <= '0;
            st_r.l0s_idle <= 1'b1;
            st_r.mps      <= BCC_MPS_RESET;
            st_r.mrrs     <= BCC_MRRS_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_sticky_nrst)
    begin
        if (!i_sticky_nrst)
        begin
            sk_r <= '0;
        end
        else
        begin
            sk_r <= sk_nxt;
        end
    end

    // slot clock gating: code 11 holds low, forward mode only
    logic [BCC_NUM_SLOT_CLKS-1:0] slot_clk;
    for (genvar g = 0; g < BCC_NUM_SLOT_CLKS; g++)
    begin : g_slot_clk
        assign slot_clk[g] = i_slot_ref_clk && !st_r.clk_stopped &&
                             (i_reverse_mode || st_r.clk_en[g*2 +: 2] != BCC_CLK_STOP_CODE);
    end

    assign {o_slot3_bus_clock_out, o_slot2_bus_clock_out, o_slot1_bus_clock_out, o_slot0_bus_clock_out} = slot_clk;
    assign o_slot_bus_clock_out  = i_slot_ref_clk && !st_r.clk_stopped;

    assign o_wake_request_out  = sk_r.wake_en && sk_r.wake_sts;
    assign o_cfg_rdata         = st_r.rdata;
    assign o_cfg_rvalid        = st_r.rvalid;
    assign o_clkrun_enable     = st_r.clkrun_en;
    assign o_l0s_need_rx_idle  = st_r.l0s_idle;
    assign o_err_report_enable = st_r.err_rep_en;
    assign o_max_payload       = st_r.mps;
    assign o_max_read_request  = st_r.mrrs;
    assign o_ext_tag_enable    = st_r.ext_tag;
    assign o_no_snoop_attr     = 1'b0;
    assign o_cfg_retry_enable  = st_r.cfg_retry;

endmodule : bcc_regs

/* verif/bcc_host.sv */
// configuration requester standing in for the upstream root complex
// assumes one core clock; requests change 1 ns after a rising edge
module bcc_host
(
    input  wire logic        i_core_clk,
    input  wire logic [31:0] i_cfg_rdata,
    input  wire logic        i_cfg_rvalid,
    output logic             o_cfg_wr,
    output logic             o_cfg_rd,
    output logic [7:0]       o_cfg_addr,
    output logic [3:0]       o_cfg_be,
    output logic [31:0]      o_cfg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus shows inverted leftovers so stale values never look live
    initial
    begin
        {o_cfg_wr, o_cfg_rd, o_cfg_addr, o_cfg_be, o_cfg_wdata} = '0;
    end

    // one write, taken at the next edge, no answer
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge i_core_clk);
        #1;
        o_cfg_wr    = 1'b1;
        o_cfg_addr  = a;
        o_cfg_be    = b;
        o_cfg_wdata = d;
        @(posedge i_core_clk);
        #1;
        o_cfg_wr    = 1'b0;
        o_cfg_addr  = ~a;
        o_cfg_be    = ~b;
        o_cfg_wdata = ~d;
    endtask : wr

    // one read; answer is in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
        @(posedge i_core_clk);
        #1;
        o_cfg_rd   = 1'b1;
        o_cfg_addr = a;
        @(posedge i_core_clk);
        #1;
        o_cfg_rd   = 1'b0;
        o_cfg_addr = ~a;
        d          = i_cfg_rdata;
        v          = i_cfg_rvalid;
    endtask : rd
endmodule : bcc_host

/* verif/bcc_regs_props.sv */
// assertion checker for the capability register bank
// assumes one core clock domain and the bank's port timing
module bcc_props
    import bcc_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_rd,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic [3:0]  i_cfg_be,
    input  wire logic [31:0] i_cfg_wdata,
    input  wire logic        i_reverse_mode,
    input  wire logic        o_cfg_rvalid,
    input  wire logic        o_wake_request_out,
    input  wire logic        o_slot0_bus_clock_out,
    input  wire logic        o_clkrun_enable,
    input  wire logic        o_l0s_need_rx_idle,
    input  wire logic [3:0]  o_err_report_enable,
    input  wire logic [2:0]  o_max_payload,
    input  wire logic [2:0]  o_max_read_request,
    input  wire logic        o_ext_tag_enable,
    input  wire logic        o_no_snoop_attr
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    // write strobes per dword, to keep the properties short
    logic wr_pm;
    logic wr_clk;
    logic wr_dev;
    assign wr_pm  = i_cfg_wr && i_cfg_addr == BCC_OFS_PM_CSR;
    assign wr_clk = i_cfg_wr && i_cfg_addr == BCC_OFS_CLK_CTRL;
    assign wr_dev = i_cfg_wr && i_cfg_addr == BCC_OFS_DEV_CTRL;

    read_answer_a: assert property (i_cfg_rd |=> o_cfg_rvalid)
        else $error("read not answered in the next cycle");
    answer_only_a: assert property (!i_cfg_rd |=> !o_cfg_rvalid)
        else $error("answer without a read");
    wake_gate_a: assert property (wr_pm && i_cfg_be[1] && !i_cfg_wdata[8] |=> !o_wake_request_out)
        else $error("wake request with wake enable cleared");
    slot_stop_a: assert property (wr_clk && i_cfg_be[0] && i_cfg_wdata[1:0] == BCC_CLK_STOP_CODE
        && !i_reverse_mode |=> !o_slot0_bus_clock_out)
        else $error("stopped slot clock not low");
    clkrun_en_a: assert property (wr_clk && i_cfg_be[1] |=> o_clkrun_enable == $past(i_cfg_wdata[14]))
        else $error("clock-run enable not written");
    l0s_idle_a: assert property (wr_clk && i_cfg_be[2] |=> o_l0s_need_rx_idle == $past(i_cfg_wdata[16]))
        else $error("l0s control not written");
    err_enable_a: assert property (wr_dev && i_cfg_be[0] |=> o_err_report_enable == $past(i_cfg_wdata[3:0]))
        else $error("error reporting enables not written");
    payload_lim_a: assert property (wr_dev && i_cfg_be[0] |=> o_max_payload == $past(i_cfg_wdata[7:5]))
        else $error("payload limit not written");
    read_size_a: assert property (wr_dev && i_cfg_be[1] |=> o_max_read_request == $past(i_cfg_wdata[14:12]))
        else $error("read request size not written");
    ext_tag_a: assert property (wr_dev && i_cfg_be[1] |=> o_ext_tag_enable == $past(i_cfg_wdata[8]))
        else $error("extended tag enable not written");
    no_snoop_a: assert property (o_no_snoop_attr == 1'b0)
        else $error("no-snoop attribute set");

    // main scenarios reached
    cover property (o_cfg_rvalid);
    cover property (o_wake_request_out);
    cover property (wr_clk && i_cfg_wdata[14]);
endmodule : bcc_props

bind bcc_regs bcc_props chk (.*);

/* verif/bcc_regs_test.sv */
// self-checking bench for the capability register bank
// assumes bcc_regs, bcc_host and the bound checker are compiled first
module bcc_regs_test;
    import bcc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 0, nrst, snrst, wr, rd, rvalid, rev, hp, sid, wake, rclk = 0;
    logic        idle, pend, plm, wk, s0, s1, s2, s3, sb, crun, l0s, etag, nsn, retry;
    logic [7:0]  addr, plv;
    logic [3:0]  be, err, erren;
    logic [31:0] wdata, rdata;
    logic [1:0]  pls;
    logic [2:0]  mps, mrrs;
    logic [4:0]  hi;
    int          miscompares = 0;
    int          checks = 0;

    // slot reference clock runs at its own unrelated rate
    always #5 clk = ~clk;
    always #17 rclk = ~rclk;

    bcc_regs uut (.i_core_clk(clk), .i_nrst(nrst), .i_sticky_nrst(snrst), .i_cfg_wr(wr), .i_cfg_rd(rd),
        .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
        .i_reverse_mode(rev), .i_hotplug_strap(hp), .i_slot_id_enable(sid), .i_wake_event(wake),
        .i_slot_ref_clk(rclk), .i_sec_bus_idle(idle), .i_primary_req_pending(pend),
        .i_power_limit_msg(plm), .i_power_limit_value(plv), .i_power_limit_scale(pls), .i_err_event(err),
        .o_wake_request_out(wk), .o_slot0_bus_clock_out(s0), .o_slot1_bus_clock_out(s1),
        .o_slot2_bus_clock_out(s2), .o_slot3_bus_clock_out(s3), .o_slot_bus_clock_out(sb),
        .o_clkrun_enable(crun), .o_l0s_need_rx_idle(l0s), .o_err_report_enable(erren),
        .o_max_payload(mps), .o_max_read_request(mrrs), .o_ext_tag_enable(etag),
        .o_no_snoop_attr(nsn), .o_cfg_retry_enable(retry));

    bcc_host host (.i_core_clk(clk), .i_cfg_rdata(rdata), .i_cfg_rvalid(rvalid), .o_cfg_wr(wr),
        .o_cfg_rd(rd), .o_cfg_addr(addr), .o_cfg_be(be), .o_cfg_wdata(wdata));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        logic        v;
        host.rd(a, d, v);
        chk("rvalid", {31'h0, v}, 32'h1);
        chk(nm, d, e);
    endtask : rdc

    // one-cycle pulse on the event inputs
    task automatic pulse(input logic [3:0] e, input logic w, input logic p);
        @(posedge clk);
        #1;
        err  = e;
        wake = w;
        plm  = p;
        @(posedge clk);
        #1;
        err  = 4'h0;
        wake = 1'b0;
        plm  = 1'b0;
    endtask : pulse

    // straps change under reset; sampled after release
    task automatic reset_with(input logic r, input logic h, input logic s);
        @(posedge clk);
        #1;
        nrst = 1'b0;
        rev  = r;
        hp   = h;
        sid  = s;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
    endtask : reset_with

    // which slot clocks toggle high within a few reference periods
    task automatic clk_seen(output logic [4:0] h);
        h = 5'h00;
        repeat (35)
        begin
            #2;
            h = h | {sb, s3, s2, s1, s0};
        end
    endtask : clk_seen

    task automatic t_defaults;
        chk("ports", {erren, mps, mrrs, etag, nsn, retry, l0s, crun, wk}, {4'h0, 3'h0, BCC_MRRS_RESET, 6'h04});
        rdc(BCC_OFS_PM_CSR, 32'h0000_0000, "pm");
        rdc(BCC_OFS_SLOT_ID, 32'h0000_0000, "slot id off");
        rdc(BCC_OFS_CLK_CTRL, 32'h0001_0000, "clk ctrl");
        rdc(BCC_OFS_SUBSYS, 32'h0000_b00d, "subsys hdr");
        rdc(BCC_OFS_SUBSYS_ID, {BCC_CARD_MODEL, BCC_CARD_MAKER}, "ids");
        rdc(BCC_OFS_EXP_CAP, 32'h0071_f010, "exp hdr");
        rdc(BCC_OFS_DEV_CAP, 32'h0000_8022, "dev cap");
        rdc(BCC_OFS_DEV_CTRL, 32'h0010_2000, "dev ctrl");
        rdc(8'h98, 32'h0000_0000, "unmapped");
    endtask : t_defaults

    task automatic t_ctrl;
        host.wr(BCC_OFS_DEV_CTRL, 4'h3, 32'hffff_ffff);
        chk("ctrl ports", {erren, mps, mrrs, etag, nsn, retry}, {4'hf, 3'h7, 3'h7, 3'h5});
        rdc(BCC_OFS_DEV_CTRL, 32'h0010_f1ef, "ctrl ones");
        host.wr(BCC_OFS_DEV_CTRL, 4'h3, 32'h0000_0000);
        chk("ctrl zero", {erren, mps, mrrs, etag, retry}, 32'h0);
    endtask : t_ctrl

    task automatic t_status;
        pulse(4'hf, 1'b0, 1'b0);
        rdc(BCC_OFS_DEV_CTRL, 32'h001f_0000, "err set");
        host.wr(BCC_OFS_DEV_CTRL, 4'h3, 32'h000f_0000);
        rdc(BCC_OFS_DEV_CTRL, 32'h001f_0000, "lane off");
        host.wr(BCC_OFS_DEV_CTRL, 4'h4, 32'h0005_0000);
        rdc(BCC_OFS_DEV_CTRL, 32'h001a_0000, "w1c");
        host.wr(BCC_OFS_DEV_CTRL, 4'h4, 32'h0000_0000);
        rdc(BCC_OFS_DEV_CTRL, 32'h001a_0000, "w0");
    endtask : t_status

    task automatic t_wake;
        host.wr(BCC_OFS_PM_CSR, 4'h2, 32'h0000_0100);
        chk("wake idle", wk, 1'b0);
        pulse(4'h0, 1'b1, 1'b0);
        chk("wake on", wk, 1'b1);
        reset_with(1'b0, 1'b0, 1'b0);
        chk("wake kept", wk, 1'b1);
        rdc(BCC_OFS_PM_CSR, 32'h0000_8100, "sticky");
        host.wr(BCC_OFS_PM_CSR, 4'h2, 32'h0000_8100);
        chk("wake clr", wk, 1'b0);
        pulse(4'h0, 1'b1, 1'b0);
        host.wr(BCC_OFS_PM_CSR, 4'h2, 32'h0000_0000);
        chk("wake gated", wk, 1'b0);
        host.wr(BCC_OFS_PM_CSR, 4'h1, 32'h0000_0003);
        host.wr(BCC_OFS_PM_CSR, 4'h1, 32'h0000_0001);
        host.wr(BCC_OFS_PM_CSR, 4'h1, 32'h0000_0002);
        rdc(BCC_OFS_PM_CSR, 32'h0000_8003, "d3 kept");
    endtask : t_wake

    task automatic t_clocks;
        // all codes per slot, then both stop modes (left in D3)
        for (int n = 0; n < 4; n++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                host.wr(BCC_OFS_CLK_CTRL, 4'h1, 32'(c) << (2 * n));
                clk_seen(hi);
                chk("slot clk", hi, (c == 3) ? 5'h1f & ~(5'h01 << n) : 5'h1f);
            end
        end
        host.wr(BCC_OFS_CLK_CTRL, 4'h3, 32'h0000_4000);
        chk("clkrun", crun, 1'b1);
        rdc(BCC_OFS_CLK_CTRL, 32'h0001_6000, "d3 stop");
        clk_seen(hi);
        chk("stopped", hi, 5'h00);
        pend = 1'b1;
        idle = 1'b1;
        host.wr(BCC_OFS_CLK_CTRL, 4'h2, 32'h0000_c000);
        rdc(BCC_OFS_CLK_CTRL, 32'h0001_c000, "pending");
        pend = 1'b0;
        rdc(BCC_OFS_CLK_CTRL, 32'h0001_e000, "idle stop");
        host.wr(BCC_OFS_CLK_CTRL, 4'h4, 32'h0000_0000);
        chk("l0s", l0s, 1'b0);
        host.wr(BCC_OFS_CLK_CTRL, 4'h2, 32'h0000_0000);
        rdc(BCC_OFS_CLK_CTRL, 32'h0000_0000, "clk off");
    endtask : t_clocks

    task automatic t_limit;
        plv = 8'ha5;
        pls = 2'h2;
        pulse(4'h0, 1'b0, 1'b1);
        host.wr(BCC_OFS_DEV_CAP, 4'hf, 32'hffff_ffff);
        rdc(BCC_OFS_DEV_CAP, 32'h0a94_8022, "limit");
    endtask : t_limit

    task automatic t_straps;
        reset_with(1'b1, 1'b1, 1'b1);
        rdc(BCC_OFS_EXP_CAP, 32'h0181_f010, "reverse");
        rdc(BCC_OFS_SUBSYS, 32'h0000_a00d, "chain slot");
        host.wr(BCC_OFS_SLOT_ID, 4'hc, 32'hffff_ffff);
        rdc(BCC_OFS_SLOT_ID, 32'hff3f_b004, "slot id");
        rdc(BCC_OFS_DEV_CAP, 32'h0000_8022, "hp reverse");
        reset_with(1'b0, 1'b1, 1'b0);
        rdc(BCC_OFS_DEV_CAP, 32'h0000_f022, "hp forward");
        rdc(BCC_OFS_SUBSYS, 32'h0000_b00d, "chain plain");
        host.wr(BCC_OFS_CLK_CTRL, 4'h2, 32'h0000_4000);
        rdc(BCC_OFS_CLK_CTRL, 32'h0001_4000, "d0 runs");
    endtask : t_straps

    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    // main sequence
    initial
    begin
        {nrst, snrst, rev, hp, sid, wake, idle, pend, plm} = 9'h000;
        err = 4'h0;
        plv = 8'h00;
        pls = 2'h0;
        repeat (20) @(posedge clk);
        #1;
        nrst  = 1'b1;
        snrst = 1'b1;
        repeat (5) @(posedge clk);
        t_defaults();
        t_ctrl();
        t_status();
        t_wake();
        t_clocks();
        t_limit();
        t_straps();
        end_sim();
    end

    // watchdog well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end
endmodule : bcc_regs_test
